/* rtl/enc_io_regs.vh */
// Register map, field positions and timing constants of the encoder in/out block
`ifndef ENC_IO_REGS_VH
`define ENC_IO_REGS_VH
`define ADDR_CTRL        4'h0
`define ADDR_OUT_LINES   4'h1
`define ADDR_EDGE_GAP    4'h2
`define ADDR_ANGLE       4'h3
`define ADDR_IN_LINES    4'h4
`define ADDR_IN_POS      4'h5
`define ADDR_IN_LATCH    4'h6
`define ADDR_STATUS      4'h7
`define CTRL_IDX_EN      0
`define CTRL_PD_MODE     1
`define CTRL_IN_CLR      2
`define CTRL_RESET       32'h0000_0001
`define OUT_LINES_RESET  15'h0400
`define OUT_LINES_MAX    15'h2000
`define OUT_LINES_TOP    15'h4000
`define IN_LINES_RESET   29'h0000_0400
`define IN_LINES_MAX     29'h1000_0000
`define EDGE_GAP_RESET   16'h0000
`define ANGLE_BITS       16
`define IDX_PHASE        17'h2
`define SYNC_WARM        2'h3
`define MIN_EDGE_NS      200
`define CLK_NS           20
`define MIN_EDGE_CYC     ((`MIN_EDGE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

/* rtl/incremental_encoder_in_out.v */
// Incremental encoder input decoder and incremental encoder output emulator
// Functional notes
// - Output tracks A and B follow the rotor angle, scaled to the programmed lines per turn.
// - The output line count is programmable from 1 to 8192 and also exactly 16384.
// - The index output is high once per turn for a quarter line while A and B are both high.
// - A control bit turns the index output off while A and B keep running.
// - A programmable minimum gap between output edges caps the output edge rate.
// - With no gap set the emulator can step one edge per clock, far above 1.8 MHz lines/s.
// - The input decodes A, B and index N with a line count from 1 to 2^28.
// - A mode bit makes the two track inputs act as step pulse and direction.
`timescale 1ns/1ps
`default_nettype none
`include "enc_io_regs.vh"
module incremental_encoder_in_out (
   // Clock and reset
   input  wire        sys_clk,
   input  wire        rstn,
   // Avalon-MM slave
   input  wire [3:0]  address,
   input  wire        read,
   input  wire        write,
   input  wire [31:0] writedata,
   output reg  [31:0] readdata,
   output wire        waitrequest,
   // Rotor angle from the position sensor
   input  wire [15:0] rotor_angle,
   // Encoder input pins (A/step, B/direction, N/reset)
   input  wire        in_a,
   input  wire        in_b,
   input  wire        in_n,
   // Emulated encoder output pins
   output reg         out_a,
   output reg         out_b,
   output reg         out_n
);
   // Software-visible settings and counts
   reg  [31:0] ctrl;
   reg  [14:0] out_lines;
   reg  [15:0] edge_gap;
   reg  [28:0] in_lines;
   reg  [31:0] in_pos;
   reg  [31:0] in_latch;
   // Bus handshake: high in the answer cycle of each access
   reg         ack;
   // Pin synchroniser, three stages deep
   reg  [2:0]  s1;
   reg  [2:0]  s2;
   reg  [2:0]  s3;
   // Emulator pipeline: sampled angle, target and current edge positions
   reg  [15:0] ang;
   reg  [16:0] tgt;
   reg  [16:0] cur;
   reg  [15:0] gap_cnt;
   // Full product of angle and edges per turn; none of its bits may be dropped
   reg  [32:0] prod;
   reg  [16:0] diff;
   // Stages of the pin synchroniser that already hold a real sample
   reg  [1:0]  warm;

   // Control fields
   wire        idx_en = ctrl[`CTRL_IDX_EN];
   wire        pd     = ctrl[`CTRL_PD_MODE];
   wire        access = read | write;
   // Period of the emulated tracks in edges: four per line
   wire [16:0] period4 = {out_lines, 2'b00};
   // Pins rest at an unknown level; until the third stage holds a real sample a
   // pin that idles high would look like a rising edge and count a false step
   wire        armed  = (warm == `SYNC_WARM);

   // One wait cycle per access: request sampled, answer on the following edge
   assign waitrequest = access & ~ack;

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ack       <= 1'b0;
         ctrl      <= `CTRL_RESET;
         out_lines <= `OUT_LINES_RESET;
         edge_gap  <= `EDGE_GAP_RESET;
         in_lines  <= `IN_LINES_RESET;
         readdata  <= 32'h0;
      end else begin
         ack <= access & ~ack;
         // Writes land on the taken edge, so a following read sees the new value
         if (write & ~ack) begin
            case (address)
               `ADDR_CTRL:      ctrl <= writedata;
               `ADDR_OUT_LINES: begin
                  // Only 1..8192 or exactly 16384 accepted; others leave the value
                  if ((writedata[14:0] != 15'h0 && writedata[14:0] <= `OUT_LINES_MAX
                       && writedata[31:15] == 17'h0)
                      || writedata == {17'h0, `OUT_LINES_TOP})
                     out_lines <= writedata[14:0];
               end
               `ADDR_EDGE_GAP:  edge_gap <= writedata[15:0];
               `ADDR_IN_LINES: begin
                  // Zero or more than 2^28 lines would break the count wrap; refused
                  if (writedata[28:0] != 29'h0 && writedata[31:0] <= {3'h0, `IN_LINES_MAX})
                     in_lines <= writedata[28:0];
               end
               default: ;
            endcase
         end
         // Read data is registered and stands until the next read
         if (read & ~ack) begin
            case (address)
               `ADDR_CTRL:      readdata <= ctrl;
               `ADDR_OUT_LINES: readdata <= {17'h0, out_lines};
               `ADDR_EDGE_GAP:  readdata <= {16'h0, edge_gap};
               `ADDR_ANGLE:     readdata <= {16'h0, ang};
               `ADDR_IN_LINES:  readdata <= {3'h0, in_lines};
               `ADDR_IN_POS:    readdata <= in_pos;
               `ADDR_IN_LATCH:  readdata <= in_latch;
               `ADDR_STATUS:    readdata <= {29'h0, out_n, out_b, out_a};
               default:         readdata <= 32'h0;
            endcase
         end
      end
   end

   // Input pins pass two flops; the third stage is for edge detection only
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s1 <= 3'h0;
         s2 <= 3'h0;
         s3 <= 3'h0;
         warm <= 2'h0;
      end else begin
         s1 <= {in_n, in_b, in_a};
         s2 <= s1;
         s3 <= s2;
         // Saturates once the third stage is loaded
         if (!armed)
            warm <= warm + 2'h1;
      end
   end

   // Input position: wraps at four counts per line in quadrature mode
   wire [31:0] wrap = pd ? {3'h0, in_lines} : {1'b0, in_lines, 2'b00};
   wire        a_ch = armed & (s2[0] ^ s3[0]);
   wire        b_ch = armed & (s2[1] ^ s3[1]);
   reg         up;
   reg         step;
   always @* begin
      up   = 1'b0;
      step = 1'b0;
      if (pd) begin
         step = armed & s2[0] & ~s3[0];
         up   = s2[1];
      // Both tracks changing at once is a lost edge; it is skipped rather than guessed
      end else if (a_ch ^ b_ch) begin
         step = 1'b1;
         // Phase order: A leading B counts up
         up   = a_ch ? (s2[0] ^ s2[1]) : ~(s2[0] ^ s2[1]);
      end
   end

   // A clear wins over a step in the same cycle so the count restarts at zero.
   // Limitation: the count wraps silently; software must read it often enough to unwrap it
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         in_pos   <= 32'h0;
         in_latch <= 32'h0;
      end else begin
         if ((pd && s2[2]) || (write && !ack && address == `ADDR_CTRL
                               && writedata[`CTRL_IN_CLR]))
            in_pos <= 32'h0;
         else if (step) begin
            if (up)
               in_pos <= (in_pos + 32'h1 >= wrap) ? 32'h0 : in_pos + 32'h1;
            else
               in_pos <= (in_pos == 32'h0) ? wrap - 32'h1 : in_pos - 32'h1;
         end
         if (!pd && armed && s2[2] && !s3[2])
            in_latch <= in_pos;
      end
   end

   // Emulator: target edge count = angle * 4 * lines / 2^16, walked one edge at a time
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ang     <= 16'h0;
         prod    <= 31'h0;
         tgt     <= 17'h0;
         cur     <= 17'h0;
         gap_cnt <= 16'h0;
         out_a   <= 1'b0;
         out_b   <= 1'b0;
         out_n   <= 1'b0;
      end else begin
         ang  <= rotor_angle;
         prod <= ang * period4;
         // Dropping the angle's fraction bits leaves an edge index inside the turn
         tgt  <= prod[32:`ANGLE_BITS];
         // After each edge the gap counter holds the next one back for edge_gap cycles;
         // a sudden jump of the target is therefore spread out, never dropped
         if (gap_cnt != 16'h0)
            gap_cnt <= gap_cnt - 16'h1;
         else if (tgt != cur) begin
            // Shortest way round the turn decides the direction
            if (diff < {1'b0, period4[16:1]})
               cur <= (cur + 17'h1 == period4) ? 17'h0 : cur + 17'h1;
            else
               cur <= (cur == 17'h0) ? period4 - 17'h1 : cur - 17'h1;
            gap_cnt <= edge_gap;
         end
         // Tracks are decoded from cur so they always change one at a time
         out_a <= (cur[1:0] == 2'b01) | (cur[1:0] == 2'b10);
         out_b <= cur[1];
         // Quarter line where A and B are both high, in the first line of the turn
         out_n <= idx_en & (cur == `IDX_PHASE);
      end
   end

   // Forward distance from cur to tgt around the turn; the sum cannot wrap in 17 bits,
   // since tgt stays below period4, and the result always stays below period4
   always @* begin
      diff = (tgt >= cur) ? tgt - cur : tgt + period4 - cur;
   end
endmodule // incremental_encoder_in_out
`default_nettype wire

/* verif/enc_far_end.sv */
// Far-side encoder or step controller driving the input pins
`timescale 1ns/1ps
`default_nettype none
module enc_far_end (
   // Clock and pins toward the device
   input  wire logic sys_clk,
   output var logic  in_a,
   output var logic  in_b,
   output var logic  in_n
);
   logic [1:0] ph = 2'h0;
   initial {in_a, in_b, in_n} = 3'h0;
   // 25 cycles per change keeps the pins under the 1 MHz input ceiling
   task automatic hold;
      repeat (25) @(posedge sys_clk);
   endtask
   task automatic quad(input int k);
      repeat (k < 0 ? -k : k) begin
         ph = ph + (k < 0 ? 2'h3 : 2'h1);
         @(posedge sys_clk);
         in_a <= ^ph;
         in_b <= ph[1];
         hold;
      end
   endtask
   task automatic pulse(input int k, input logic up);
      @(posedge sys_clk);
      in_b <= up;
      repeat (k) begin
         hold;
         in_a <= 1'b1;
         hold;
         in_a <= 1'b0;
      end
      hold;
   endtask
   task automatic mark;
      hold;
      in_n <= 1'b1;
      hold;
      in_n <= 1'b0;
      hold;
   endtask
endmodule // enc_far_end
`default_nettype wire

/* verif/enc_io_checker.sv */
// Port-level assertions for the encoder in/out block
`timescale 1ns/1ps
`default_nettype none
`include "enc_io_regs.vh"
module enc_io_checker (
   // Clock and reset
   input wire logic        sys_clk,
   input wire logic        rstn,
   // Avalon-MM slave
   input wire logic        read,
   input wire logic        write,
   input wire logic        waitrequest,
   input wire logic [3:0]  address,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   // Angle and pins
   input wire logic [15:0] rotor_angle,
   input wire logic        in_a,
   input wire logic        in_b,
   input wire logic        in_n,
   input wire logic        out_a,
   input wire logic        out_b,
   input wire logic        out_n
);
   logic        idx_en;
   logic [15:0] gap;
   logic [15:0] since;
   // Shadow of the control and gap registers, updated on the edge that takes a write,
   // the same edge on which the block itself loads them
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         {idx_en, gap, since} <= {1'b1, 32'h0};
      end else begin
         if (write && waitrequest && address == `ADDR_CTRL) idx_en <= writedata[`CTRL_IDX_EN];
         if (write && waitrequest && address == `ADDR_EDGE_GAP) gap <= writedata[15:0];
         since <= ($changed(out_a) || $changed(out_b)) ? 16'h0 : since + {15'h0, ~&since};
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   chk_first_wait: assert property ((read || write) && !$past(waitrequest) |-> waitrequest)
      else $error("request answered without wait state");
   chk_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("more than one wait state");
   chk_idle_nowait: assert property (!(read || write) |-> !waitrequest)
      else $error("wait state with no request");
   chk_unmapped_zero: assert property (read && !waitrequest && address[3] |-> readdata == 32'h0)
      else $error("unmapped read not zero");
   chk_single_edge: assert property (!($changed(out_a) && $changed(out_b)))
      else $error("both tracks moved at once");
   chk_index_ab: assert property (out_n |-> out_a && out_b)
      else $error("index outside A and B high");
   chk_index_off: assert property (!idx_en && !$past(idx_en, 5) |-> !out_n)
      else $error("index while disabled");
   chk_edge_gap: assert property ($changed(out_a) || $changed(out_b) |-> since >= gap)
      else $error("output edges too close");
endmodule // enc_io_checker
`default_nettype wire

/* verif/incremental_encoder_in_out_tb_top.sv */
// Self-checking bench for the encoder in/out block
`timescale 1ns/1ps
`default_nettype none
`include "enc_io_regs.vh"
module incremental_encoder_in_out_tb_top;
   logic        sys_clk = 1'b0, rstn = 1'b0, read = 1'b0, write = 1'b0;
   logic [3:0]  address = 4'h0;
   logic [31:0] writedata = 32'h0, exp_v;
   logic [15:0] rotor_angle = 16'h0;
   wire  [31:0] readdata;
   wire         waitrequest, in_a, in_b, in_n, out_a, out_b, out_n;
   int          fail_count = 0, tests_run = 0, seed = 69443, pos;
   logic [31:0] exp_q[$];
   logic [31:0] lim [11][3] = '{'{1, 0, 'h400}, '{1, 'h2001, 'h400}, '{1, 'h4000, 'h4000},
      '{1, 'h2000, 'h2000}, '{1, 'h3fff, 'h2000}, '{1, 1, 1}, '{1, 4, 4}, '{4, 0, 'h400},
      '{4, 'h10000001, 'h400}, '{4, 'h10000000, 'h10000000}, '{4, 'h40, 'h40}};
   always #10 sys_clk = ~sys_clk;
   incremental_encoder_in_out u_dut (.*);
   enc_far_end u_far (.*);
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic bus(input logic [3:0] ad, input logic w, input logic [31:0] d);
      @(posedge sys_clk);
      address <= ad;
      read <= !w;
      write <= w;
      writedata <= d;
      for (int i = 0; i < 50; i++) begin
         @(posedge sys_clk);
         if (waitrequest === 1'b0) begin
            read <= 1'b0;
            write <= 1'b0;
            return;
         end
      end
      fail_count++;
      wrap_up;
   endtask
   task automatic rd(input logic [3:0] ad, input logic [31:0] ex);
      exp_q.push_back(ex);
      bus(ad, 1'b0, 32'h0);
   endtask
   always @(posedge sys_clk) begin
      if (read && waitrequest === 1'b0) begin
         exp_v = exp_q.pop_front();
         tests_run++;
         if (readdata !== exp_v) begin
            fail_count++;
            $display("MISMATCH reg %h expected %h seen %h", address, exp_v, readdata);
         end
      end
   end
   initial begin
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      rd(`ADDR_CTRL, `CTRL_RESET);
      rd(`ADDR_EDGE_GAP, 32'h0);
      bus(4'ha, 1'b1, 32'h5);
      rd(4'ha, 32'h0);
      foreach (lim[i]) begin
         bus(lim[i][0][3:0], 1'b1, lim[i][1]);
         rd(lim[i][0][3:0], lim[i][2]);
      end
      pos = 3 + ($random(seed) & 31);
      u_far.quad(pos);
      rd(`ADDR_IN_POS, pos);
      u_far.quad(-pos - 5);
      u_far.mark;
      rd(`ADDR_IN_LATCH, 32'hfb);
      bus(`ADDR_CTRL, 1'b1, 32'h7);
      rd(`ADDR_IN_POS, 32'h0);
      u_far.pulse(2, 1'b0);
      u_far.pulse(pos, 1'b1);
      rd(`ADDR_IN_POS, (pos + 62) & 63);
      u_far.mark;
      rd(`ADDR_IN_POS, 32'h0);
      for (int e = 1; e >= 0; e--) begin
         bus(`ADDR_CTRL, 1'b1, e);
         for (int j = 1; j <= 16; j++) begin
            rotor_angle <= {j[3:0], 2'b01, 10'($random(seed))};
            repeat (30) @(posedge sys_clk);
            rd(`ADDR_ANGLE, {16'h0, rotor_angle});
            rd(`ADDR_STATUS, {29'h0, e[0] && j == 2, j[1], ^j[1:0]});
         end
      end
      bus(`ADDR_EDGE_GAP, 1'b1, 32'h9);
      rotor_angle <= 16'h7800;
      // With ten cycles per edge only two of the seven steps are done here
      repeat (20) @(posedge sys_clk);
      rd(`ADDR_STATUS, 32'h3);
      repeat (60) @(posedge sys_clk);
      rd(`ADDR_STATUS, 32'h2);
      bus(`ADDR_EDGE_GAP, 1'b1, 32'h0);
      rotor_angle <= 16'he800;
      repeat (14) @(posedge sys_clk);
      rd(`ADDR_STATUS, 32'h3);
      wrap_up;
   end
endmodule // incremental_encoder_in_out_tb_top
bind incremental_encoder_in_out enc_io_checker u_chk (.*);
`default_nettype wire
